/* File: src/thc_param_bank.sv */
`timescale 1ns/1ps
module thc_param_bank
    import thc_pkg::*;
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic resetn,
    // access
    input wire logic imperial,
    input wire logic [3:0] sel,
    input wire logic inc,
    input wire logic dec,
    input wire logic [3:0] sel2,
    input wire logic inc2,
    input wire logic dec2,
    // full view of the active set
    output logic [16*NPAR-1:0] vals
);
    // ---------------------------------------------------------------
    // limits and steps
    // ---------------------------------------------------------------
    function automatic logic [15:0] pmin(input logic [3:0] i);
        unique case (i)
            P_SETV: pmin = SETV_MIN;
            P_PIERCE_H: pmin = PH_MIN;
            P_CUT_H: pmin = CH_MIN;
            P_GAIN: pmin = GAIN_MIN;
            P_RETRACT: pmin = RET_MIN;
            P_XFER: pmin = XF_MIN;
            default: pmin = 16'h0000;
        endcase
    endfunction : pmin

    function automatic logic [15:0] pmax(input logic [3:0] i);
        unique case (i)
            P_SETV: pmax = SETV_MAX;
            P_PIERCE_H: pmax = PH_MAX;
            P_PIERCE_T, P_LOOP_DLY, P_MARK_T: pmax = T_MAX;
            P_CUT_H: pmax = CH_MAX;
            P_GAIN: pmax = GAIN_MAX;
            P_LOCK: pmax = LOCK_MAX;
            P_RETRACT: pmax = RET_MAX;
            P_XFER: pmax = XF_MAX;
            P_MARK, P_HOME: pmax = 16'h0001;
            default: pmax = 16'h0000;
        endcase
    endfunction : pmax

    function automatic logic [15:0] pstep(input logic [3:0] i);
        pstep = (i == P_RETRACT) ? RET_STEP : 16'h0001;
    endfunction : pstep

    function automatic logic [15:0] prst(input logic [3:0] i);
        unique case (i)
            P_SETV: prst = SETV_RST;
            P_PIERCE_H: prst = PH_RST;
            P_PIERCE_T, P_LOOP_DLY, P_MARK_T: prst = T_RST;
            P_CUT_H: prst = CH_RST;
            P_GAIN: prst = GAIN_RST;
            P_LOCK: prst = LOCK_RST;
            P_RETRACT: prst = RET_RST;
            P_XFER: prst = XF_RST;
            default: prst = 16'h0000;
        endcase
    endfunction : prst

    // two independent sets, metric in slot 0
    logic [15:0] mem_q [2][NPAR];
    logic u;
    assign u = imperial;

    // ---------------------------------------------------------------
    // update
    // ---------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        for (int s = 0; s < 2; s++) begin
            for (int i = 0; i < NPAR; i++) begin
                logic [3:0] k;
                logic [16:0] up;
                k = 4'(i);
                up = {1'b0, mem_q[s][i]} + {1'b0, pstep(k)};
                if (!resetn) begin
                    mem_q[s][i] <= prst(k);
                end else if (u == s[0]
                        && ((inc && sel == k) || (inc2 && sel2 == k))) begin
                    if (up <= {1'b0, pmax(k)}) begin
                        mem_q[s][i] <= up[15:0];
                    end
                end else if (u == s[0]
                        && ((dec && sel == k) || (dec2 && sel2 == k))) begin
                    if (mem_q[s][i] >= pmin(k) + pstep(k)) begin
                        mem_q[s][i] <= mem_q[s][i] - pstep(k);
                    end
                end
            end
        end
    end

    always_comb begin
        for (int i = 0; i < NPAR; i++) begin
            vals[16*i +: 16] = mem_q[u][i];
        end
    end
endmodule : thc_param_bank

/* File: src/thc_pkg.sv */
package thc_pkg;
    // ---------------------------------------------------------------
    // parameter indices in the setup menu
    // ---------------------------------------------------------------
    localparam int NPAR = 12;
    localparam logic [3:0] P_SETV = 4'h0;
    localparam logic [3:0] P_PIERCE_H = 4'h1;
    localparam logic [3:0] P_PIERCE_T = 4'h2;
    localparam logic [3:0] P_CUT_H = 4'h3;
    localparam logic [3:0] P_LOOP_DLY = 4'h4;
    localparam logic [3:0] P_GAIN = 4'h5;
    localparam logic [3:0] P_LOCK = 4'h6;
    localparam logic [3:0] P_RETRACT = 4'h7;
    localparam logic [3:0] P_XFER = 4'h8;
    localparam logic [3:0] P_MARK = 4'h9;
    localparam logic [3:0] P_MARK_T = 4'ha;
    localparam logic [3:0] P_HOME = 4'hb;
    // ---------------------------------------------------------------
    // units: volts x2, mm x10, seconds x10, gain x10, percent
    // ---------------------------------------------------------------
    localparam logic [15:0] SETV_MIN = 16'h0032; // 25 V
    localparam logic [15:0] SETV_MAX = 16'h01f4; // 250 V
    localparam logic [15:0] SETV_RST = 16'h00f0; // 120 V
    localparam logic [15:0] PH_MIN = 16'h0014;   // 2 mm
    localparam logic [15:0] PH_MAX = 16'h00c8;   // 20 mm
    localparam logic [15:0] PH_RST = 16'h0028;
    localparam logic [15:0] T_MAX = 16'h0064;    // 10 s
    localparam logic [15:0] T_RST = 16'h0005;
    localparam logic [15:0] CH_MIN = 16'h0005;   // 0.5 mm
    localparam logic [15:0] CH_MAX = 16'h00fa;   // 25 mm
    localparam logic [15:0] CH_RST = 16'h0015;
    localparam logic [15:0] GAIN_MIN = 16'h000a;
    localparam logic [15:0] GAIN_MAX = 16'h012c;
    localparam logic [15:0] GAIN_RST = 16'h0046; // 7.0
    localparam logic [15:0] LOCK_MAX = 16'h0014;
    localparam logic [15:0] LOCK_ON_MIN = 16'h0004;
    localparam logic [15:0] LOCK_RST = 16'h000a;
    localparam logic [15:0] RET_MIN = 16'h0064;  // 10 mm
    localparam logic [15:0] RET_FULL = 16'h0258; // 60 mm
    localparam logic [15:0] RET_MAX = 16'h0262;  // one step past: full
    localparam logic [15:0] RET_RST = 16'h00c8;
    localparam logic [15:0] RET_STEP = 16'h000a; // 1 mm
    localparam logic [15:0] XF_MIN = 16'h0032;
    localparam logic [15:0] XF_MAX = 16'h01c2;
    localparam logic [15:0] XF_RST = 16'h0096;
    // ---------------------------------------------------------------
    // timing
    // ---------------------------------------------------------------
    localparam int CLK_HZ = 50_000_000;
    localparam int TICK_MS = 100;             // 0.1 s time unit
    localparam int TICK_CYC = CLK_HZ / 1000 * TICK_MS;
    localparam int HOLD_MS = 1000;            // long press
    localparam int HOLD_CYC = CLK_HZ / 1000 * HOLD_MS;
    localparam int BLINK_CYC = CLK_HZ / 4;

    typedef enum logic [1:0] {THC_MENU_OFF, THC_MENU_NAV, THC_MENU_EDIT}
        thc_menu_e;
    typedef enum logic [2:0] {THC_IDLE, THC_FIRE, THC_PIERCE, THC_DELAY,
        THC_LOOP, THC_MARK, THC_RETRACT} thc_cut_e;
endpackage : thc_pkg

/* File: src/thc_sequencer.sv */
`timescale 1ns/1ps
module thc_sequencer
    import thc_pkg::*;
#(
    parameter int TICK = TICK_CYC,
    parameter int HOLD = HOLD_CYC,
    parameter int BLINK = BLINK_CYC
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic resetn,
    // operator panel
    input wire logic height_mode_button,
    input wire logic torch_up_button,
    input wire logic torch_down_button,
    input wire logic setpoint_plus_button,
    input wire logic setpoint_minus_button,
    input wire logic imperial_units,
    input wire logic sampled_mode,
    // machine and plasma
    input wire logic cycle_start,
    input wire logic arc_transfer_ok,
    input wire logic at_cut_height,
    input wire logic [15:0] arc_voltage,
    // panel outputs
    output logic menu_escape_lamp,
    output logic correction_enabled,
    output logic save_strobe,
    output logic homing_start,
    // machine and plasma outputs
    output logic torch_fire,
    output logic motion_enable,
    output logic [15:0] target_voltage,
    output logic loop_active,
    output logic torch_raise,
    output logic torch_lower,
    output logic retract_req,
    output logic full_retract
);
    import thc_pkg::*;

    // ---------------------------------------------------------------
    // button edges and long press
    // ---------------------------------------------------------------
    logic mode_q, up_q, dn_q, pl_q, mi_q, long_q;
    logic [31:0] hold_q;
    wire mode_rel = mode_q && !height_mode_button;
    wire long_hit = height_mode_button && hold_q == 32'(HOLD - 1);
    wire short_rel = mode_rel && !long_q;
    wire up_p = torch_up_button && !up_q;
    wire dn_p = torch_down_button && !dn_q;
    wire pl_p = setpoint_plus_button && !pl_q;
    wire mi_p = setpoint_minus_button && !mi_q;

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            {mode_q, up_q, dn_q, pl_q, mi_q, long_q} <= 6'h00;
            hold_q <= 32'h0;
        end else begin
            mode_q <= height_mode_button;
            up_q <= torch_up_button;
            dn_q <= torch_down_button;
            pl_q <= setpoint_plus_button;
            mi_q <= setpoint_minus_button;
            hold_q <= height_mode_button && !long_hit ? hold_q + 32'h1
                : 32'h0;
            if (long_hit) long_q <= 1'b1;
            else if (!height_mode_button) long_q <= 1'b0;
        end
    end

    // ---------------------------------------------------------------
    // menu
    // ---------------------------------------------------------------
    thc_menu_e menu_q;
    thc_cut_e cut_q;
    logic [3:0] sel_q;
    logic esc_arm_q, corr_q, save_q, home_q;
    logic [31:0] blink_q;
    logic lamp_q;
    wire idle = cut_q == THC_IDLE;
    wire in_menu = menu_q != THC_MENU_OFF;
    wire edit = menu_q == THC_MENU_EDIT;
    wire [16*NPAR-1:0] vals;
    function automatic logic [15:0] pv(input logic [16*NPAR-1:0] v,
            input logic [3:0] i);
        pv = v[16*i +: 16];
    endfunction : pv
    wire [3:0] idle_sel = sampled_mode ? P_CUT_H : P_SETV;
    wire idle_adj = idle && !in_menu;

    thc_param_bank u_bank (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .imperial(imperial_units),
        .sel(sel_q),
        .inc(edit && pl_p),
        .dec(edit && mi_p),
        .sel2(idle_sel),
        .inc2(idle_adj && pl_p),
        .dec2(idle_adj && mi_p),
        .vals(vals)
    );

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            menu_q <= THC_MENU_OFF;
            sel_q <= 4'h0;
            esc_arm_q <= 1'b0;
            corr_q <= 1'b1;
            save_q <= 1'b0;
            home_q <= 1'b0;
            blink_q <= 32'h0;
            lamp_q <= 1'b0;
        end else begin
            save_q <= 1'b0;
            home_q <= 1'b0;
            blink_q <= blink_q == 32'(BLINK - 1) ? 32'h0 : blink_q + 32'h1;
            unique case (menu_q)
                THC_MENU_OFF: begin
                    if (long_hit && idle) begin
                        menu_q <= THC_MENU_NAV;
                        esc_arm_q <= 1'b0;
                    end else if (short_rel) begin
                        corr_q <= !corr_q;
                    end
                end
                THC_MENU_NAV: begin
                    if (mode_rel && long_q) begin
                        esc_arm_q <= 1'b1;
                    end else if (long_hit && esc_arm_q) begin
                        menu_q <= THC_MENU_OFF;
                        save_q <= 1'b1;
                        home_q <= pv(vals, P_HOME) != 16'h0;
                    end else if (short_rel) begin
                        menu_q <= THC_MENU_EDIT;
                    end else if (up_p) begin
                        sel_q <= sel_q == 4'(NPAR - 1) ? 4'h0 : sel_q + 4'h1;
                    end else if (dn_p) begin
                        sel_q <= sel_q == 4'h0 ? 4'(NPAR - 1) : sel_q - 4'h1;
                    end
                end
                THC_MENU_EDIT: begin
                    if (short_rel) menu_q <= THC_MENU_NAV;
                end
            endcase
            if (!in_menu || !esc_arm_q) lamp_q <= 1'b0;
            else if (blink_q == 32'h0) lamp_q <= !lamp_q;
        end
    end

    // ---------------------------------------------------------------
    // cutting sequence
    // ---------------------------------------------------------------
    logic [31:0] tick_q;
    logic [15:0] tenths_q, samp_q;
    logic fire_q, mot_q, loop_q, ret_q, raise_q, lower_q;
    wire tick = tick_q == 32'(TICK - 1);
    wire mark_on = pv(vals, P_MARK) != 16'h0;
    wire [15:0] target = sampled_mode ? samp_q : pv(vals, P_SETV);
    wire [31:0] lock_lim = 32'(target) * (32'd100 + 32'(pv(vals, P_LOCK)));
    wire locked = pv(vals, P_LOCK) >= LOCK_ON_MIN
        && 32'(arc_voltage) * 32'd100 > lock_lim;
    wire [15:0] err_hi = arc_voltage - target;
    wire [15:0] err_lo = target - arc_voltage;
    wire [31:0] gain_hi = 32'(err_hi) * 32'(pv(vals, P_GAIN));
    wire [31:0] gain_lo = 32'(err_lo) * 32'(pv(vals, P_GAIN));
    // gain sets how far off the error must be before a step is issued
    // long arc reads high: torch too far up, so step down, and vice versa
    wire go_up = arc_voltage < target && gain_lo >= 32'd100;
    wire go_dn = arc_voltage > target && gain_hi >= 32'd100;

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            cut_q <= THC_IDLE;
            tick_q <= 32'h0;
            tenths_q <= 16'h0;
            samp_q <= 16'h0;
            {fire_q, mot_q, loop_q, ret_q, raise_q, lower_q} <= 6'h00;
        end else begin
            tick_q <= tick ? 32'h0 : tick_q + 32'h1;
            raise_q <= 1'b0;
            lower_q <= 1'b0;
            unique case (cut_q)
                THC_IDLE: begin
                    ret_q <= 1'b0;
                    tenths_q <= 16'h0;
                    if (cycle_start && !in_menu) begin
                        fire_q <= 1'b1;
                        cut_q <= mark_on ? THC_MARK : THC_FIRE;
                    end
                end
                THC_MARK: begin
                    if (arc_transfer_ok && tick) tenths_q <= tenths_q + 16'h1;
                    if (!cycle_start || (arc_transfer_ok
                            && tenths_q >= pv(vals, P_MARK_T))) begin
                        fire_q <= 1'b0;
                        cut_q <= THC_RETRACT;
                    end
                end
                THC_FIRE: begin
                    if (!cycle_start) cut_q <= THC_RETRACT;
                    else if (arc_transfer_ok) cut_q <= THC_PIERCE;
                end
                THC_PIERCE: begin
                    if (tick) tenths_q <= tenths_q + 16'h1;
                    if (!cycle_start) cut_q <= THC_RETRACT;
                    else if (tenths_q >= pv(vals, P_PIERCE_T)) begin
                        mot_q <= 1'b1;
                        tenths_q <= 16'h0;
                        cut_q <= THC_DELAY;
                    end
                end
                THC_DELAY: begin
                    if (tick && at_cut_height) tenths_q <= tenths_q + 16'h1;
                    if (!cycle_start) cut_q <= THC_RETRACT;
                    else if (at_cut_height
                            && tenths_q >= pv(vals, P_LOOP_DLY)) begin
                        samp_q <= arc_voltage;
                        loop_q <= 1'b1;
                        cut_q <= THC_LOOP;
                    end
                end
                THC_LOOP: begin
                    if (!cycle_start) begin
                        cut_q <= THC_RETRACT;
                    end else if (corr_q && !locked) begin
                        raise_q <= go_up;
                        lower_q <= go_dn;
                    end
                end
                THC_RETRACT: begin
                    {fire_q, mot_q, loop_q} <= 3'h0;
                    ret_q <= 1'b1;
                    cut_q <= THC_IDLE;
                end
                default: cut_q <= THC_IDLE;
            endcase
        end
    end

    // ---------------------------------------------------------------
    // registered outputs
    // ---------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            target_voltage <= 16'h0;
            full_retract <= 1'b0;
        end else begin
            target_voltage <= target;
            full_retract <= pv(vals, P_RETRACT) > RET_FULL;
        end
    end
    assign menu_escape_lamp = lamp_q;
    assign correction_enabled = corr_q;
    assign save_strobe = save_q;
    assign homing_start = home_q;
    assign torch_fire = fire_q;
    assign motion_enable = mot_q;
    assign loop_active = loop_q;
    assign torch_raise = raise_q;
    assign torch_lower = lower_q;
    assign retract_req = ret_q;

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    sequence s_cut_end;
        loop_q && cut_q == THC_LOOP && !cycle_start;
    endsequence
    property p_loop_end;
        @(posedge ref_clk) disable iff (!resetn)
        s_cut_end |=> ##1 !loop_q ##0 ret_q;
    endproperty
    a_loop_end: assert property (p_loop_end) else $error("loop end");
    property p_no_corr;
        @(posedge ref_clk) disable iff (!resetn)
        !corr_q |=> !raise_q && !lower_q;
    endproperty
    a_no_corr: assert property (p_no_corr) else $error("corr off");
    property p_lock;
        @(posedge ref_clk) disable iff (!resetn)
        locked |=> !lower_q && !raise_q;
    endproperty
    a_lock: assert property (p_lock) else $error("lock");
    property p_dir;
        @(posedge ref_clk) disable iff (!resetn)
        raise_q |-> $past(arc_voltage) < $past(target);
    endproperty
    a_dir: assert property (p_dir) else $error("direction");
    property p_motion;
        @(posedge ref_clk) disable iff (!resetn)
        $rose(mot_q) |-> $past(cut_q) == THC_PIERCE;
    endproperty
    a_motion: assert property (p_motion) else $error("motion");
    property p_sample;
        @(posedge ref_clk) disable iff (!resetn)
        $rose(loop_q) |-> samp_q == $past(arc_voltage);
    endproperty
    a_sample: assert property (p_sample) else $error("sample");
    property p_save;
        @(posedge ref_clk) disable iff (!resetn)
        save_q |-> menu_q == THC_MENU_OFF && $past(menu_q) == THC_MENU_NAV;
    endproperty
    a_save: assert property (p_save) else $error("save");
    property p_lamp;
        @(posedge ref_clk) disable iff (!resetn)
        !in_menu |=> !lamp_q;
    endproperty
    a_lamp: assert property (p_lamp) else $error("lamp");
endmodule : thc_sequencer

/* File: tb/test_torch_height_cut_sequencer.sv */
`timescale 1ns/1ps
module test_torch_height_cut_sequencer;
    import thc_pkg::*;
    // ----
    // setup
    // ----
    localparam int TK = 10;
    localparam int HD = 20;
    typedef struct packed {
        logic s;
        logic [15:0] v;
        logic [15:0] t;
        logic [1:0] d;
    } thc_row_s;
    // last row sits past the lock level, so no steps
    thc_row_s rows [4] = '{'{1'b0, 16'h00f8, 16'h00f0, 2'b10},
        '{1'b0, 16'h00e0, 16'h00f0, 2'b01},
        '{1'b1, 16'h0130, 16'h0130, 2'b00},
        '{1'b0, 16'h0120, 16'h00f0, 2'b00}};
    logic ref_clk = 1'b0;
    logic resetn = 1'b0;
    logic [4:0] btn_q = 5'h00;
    logic imp_q = 1'b0;
    logic smp_q = 1'b0;
    logic start_q = 1'b0;
    logic [15:0] volt_q = 16'h0000;
    logic cs, ok, ach, lamp, corr, save, home, fire, mot, lp;
    logic rse, lwr, retr, full, saved, homed;
    logic [15:0] av, tgt;
    int n_fail = 0;
    int total_checks = 0;
    int cyc = 0;
    int i;
    int m;
    thc_sequencer #(.TICK(TK), .HOLD(HD), .BLINK(4)) u_thc_sequencer (
        .ref_clk(ref_clk), .resetn(resetn),
        .height_mode_button(btn_q[0]), .torch_up_button(btn_q[1]),
        .torch_down_button(btn_q[2]), .setpoint_plus_button(btn_q[3]),
        .setpoint_minus_button(btn_q[4]), .imperial_units(imp_q),
        .sampled_mode(smp_q), .cycle_start(cs), .arc_transfer_ok(ok),
        .at_cut_height(ach), .arc_voltage(av), .menu_escape_lamp(lamp),
        .correction_enabled(corr), .save_strobe(save), .homing_start(home),
        .torch_fire(fire), .motion_enable(mot), .target_voltage(tgt),
        .loop_active(lp), .torch_raise(rse), .torch_lower(lwr),
        .retract_req(retr), .full_retract(full));
    thc_plant_model u_thc_plant_model (
        .ref_clk(ref_clk), .resetn(resetn), .start_req(start_q),
        .volt_base(volt_q), .torch_fire(fire), .motion_enable(mot),
        .cycle_start(cs), .arc_transfer_ok(ok), .at_cut_height(ach),
        .arc_voltage(av));
    // ----
    // tasks
    // ----
    task automatic results();
        if (n_fail == 0 && total_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : results
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        total_checks++;
        if (g !== e) begin
            n_fail++;
            $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk
    // sample one step after the edge, once its updates have landed
    task automatic tick();
        @(posedge ref_clk);
        #1;
        if (save === 1'b1) saved = 1'b1;
        if (home === 1'b1) homed = 1'b1;
    endtask : tick
    task automatic press(input int b, input int n);
        btn_q[b] <= 1'b1;
        repeat (n) tick();
        btn_q[b] <= 1'b0;
        repeat (3) tick();
    endtask : press
    task automatic cut(input logic s, input logic [15:0] v,
        input logic [15:0] t, input logic [1:0] d);
        int n;
        int m;
        logic [1:0] seen;
        smp_q <= s;
        volt_q <= v;
        start_q <= 1'b1;
        n = 0;
        m = 0;
        seen = 2'b00;
        while (lp !== 1'b1 && n < 400) begin
            tick();
            n++;
            if (mot === 1'b1 && m == 0) m = n;
        end
        chk(16'(m > 40 && m < 70), 16'h0001);
        chk(16'(n - m > 40 && n - m < 70), 16'h0001);
        // target output is registered one cycle behind the sample
        tick();
        chk(tgt, t);
        chk(16'({fire, mot}), 16'h0003);
        repeat (30) begin
            tick();
            seen = seen | {lwr, rse};
        end
        chk(16'(seen), 16'(d));
        start_q <= 1'b0;
        n = 0;
        while (retr !== 1'b1 && n < 20) begin
            tick();
            n++;
        end
        chk(16'({n < 20, full}), 16'h0002);
        repeat (2) tick();
        chk(16'({fire, lp}), 16'h0000);
    endtask : cut
    // ----
    // run
    // ----
    initial begin
        forever #10 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_fail++;
            results();
        end
    end
    initial begin
        saved = 1'b0;
        homed = 1'b0;
        repeat (6) @(posedge ref_clk);
        chk(16'({corr, tgt == 16'h0000, fire, retr}), 16'h000c);
        resetn <= 1'b1;
        tick();
        chk(16'({corr, fire, mot, lp, lamp}), 16'h0010);
        chk(tgt, SETV_RST);
        for (i = 0; i < 4; i++) begin
            cut(rows[i].s, rows[i].v, rows[i].t, rows[i].d);
        end
        press(0, 1);
        chk(16'(corr), 16'h0000);
        cut(1'b0, 16'h00e0, 16'h00f0, 2'b00);
        press(0, 1);
        chk(16'(corr), 16'h0001);
        press(0, HD + 2);
        i = 0;
        while (lamp !== 1'b1 && i < 12) begin
            tick();
            i++;
        end
        chk(16'(i < 12), 16'h0001);
        press(1, 1);
        press(2, 1);
        press(0, 1);
        press(3, 1);
        press(0, 1);
        press(0, HD + 2);
        chk(16'({saved, homed}), 16'h0002);
        press(3, 1);
        smp_q <= 1'b1;
        press(4, 1);
        cut(1'b0, 16'h00f2, 16'h00f2, 2'b00);
        imp_q <= 1'b1;
        cut(1'b0, 16'h00f0, SETV_RST, 2'b00);
        // second session: homing yes, then marking on
        press(0, HD + 2);
        press(2, 1);
        press(0, 1);
        press(3, 1);
        press(0, 1);
        press(2, 1);
        press(2, 1);
        press(0, 1);
        press(3, 1);
        press(0, 1);
        press(0, HD + 2);
        chk(16'(homed), 16'h0001);
        // start must drop at once, or the held start fires a second mark
        start_q <= 1'b1;
        i = 0;
        while (fire !== 1'b1 && i < 20) begin
            tick();
            i++;
        end
        m = 0;
        while (fire === 1'b1 && m < 200) begin
            tick();
            m++;
            if (mot === 1'b1) m = 300;
        end
        start_q <= 1'b0;
        chk(16'(i < 20 && m > 40 && m < 70), 16'h0001);
        repeat (3) tick();
        chk(16'({fire, mot, lp}), 16'h0000);
        results();
    end
endmodule : test_torch_height_cut_sequencer

/* File: tb/thc_plant_model.sv */
`timescale 1ns/1ps
module thc_plant_model (
    // clock and reset
    input wire logic ref_clk,
    input wire logic resetn,
    // bench control
    input wire logic start_req,
    input wire logic [15:0] volt_base,
    // from the sequencer
    input wire logic torch_fire,
    input wire logic motion_enable,
    // to the sequencer
    output logic cycle_start,
    output logic arc_transfer_ok,
    output logic at_cut_height,
    output logic [15:0] arc_voltage
);
    // arc needs three cycles to transfer, so ok rises three cycles after fire and only while fire stays high
    logic [1:0] arc_dly_q;
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            cycle_start <= 1'b0;
            arc_dly_q <= 2'b00;
            arc_transfer_ok <= 1'b0;
            at_cut_height <= 1'b0;
            arc_voltage <= 16'h0000;
        end else begin
            cycle_start <= start_req;
            arc_dly_q <= {arc_dly_q[0], torch_fire};
            arc_transfer_ok <= arc_dly_q[1] & torch_fire;
            at_cut_height <= motion_enable;
            // no arc, no voltage
            arc_voltage <= arc_transfer_ok ? volt_base : 16'h0000;
        end
    end
endmodule : thc_plant_model
